// file: src/trc_pkg.sv
// Package for the timer run-control block
package trc_pkg;
    // Register address map (byte addresses, one word apart, index = address / 4)
    localparam logic [7:0] ADDR_CONF   = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_COUNT  = 8'h08;
    localparam logic [7:0] ADDR_MODULO = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK   = 8'h14;

    // Configuration field positions
    localparam int TRG_SRC_LO   = 24;
    localparam int TRG_SRC_W    = 4;
    localparam int RELOAD_BIT   = 18;
    localparam int STOP_OVF_BIT = 17;
    localparam int START_TRG_BIT = 16;
    localparam int GTB_BIT      = 9;
    localparam int DBG_LO       = 6;
    localparam int WAIT_BIT     = 5;

    // Writable bits of the configuration register
    localparam logic [31:0] CONF_WMASK = 32'h0f07_02e0;
    localparam logic [31:0] CONF_RESET = 32'h0000_0000;

    // Debug behaviour codes
    localparam logic [1:0] DBG_PAUSE    = 2'h0;
    localparam logic [1:0] DBG_CONTINUE = 2'h3;

    // Status bits
    localparam int ST_OVF = 0;
    localparam int ST_TRG = 1;
    localparam int ST_W   = 2;

    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] MODULO_RESET = 16'hffff;

    typedef struct packed {
        logic [3:0] trigger_source_select;
        logic       reload_on_trigger_edge;
        logic       stop_on_overflow;
        logic       start_on_trigger_edge;
        logic       global_timebase_select;
        logic [1:0] debug_behaviour;
        logic       wait_pause_select;
    } trc_conf_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_WAIT    = 3'b010,
        ST_RUN     = 3'b100
    } trc_state_t;
endpackage

// file: src/trc_edge_detect.sv
// Trigger synchroniser and single-shot rising edge detector
`timescale 1ns/10ps
module trc_edge_detect #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Trigger inputs and selection
    input  wire logic [WIDTH-1:0] trig_in,
    input  wire logic [3:0]       sel,
    // One-cycle rising edge of the selected trigger
    output logic                  rise
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic             last_r;
    logic             cur;

    // Two-stage synchroniser; first stage read only by second
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= trig_in;
            sync_r <= meta_r;
        end
    end

    assign cur = sync_r[sel];

    // Edge acts once: compare against previous synced level
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            last_r <= 1'b0;
            rise   <= 1'b0;
        end
        else
        begin
            last_r <= cur;
            rise   <= cur & ~last_r;
        end
    end
endmodule

// file: src/trc_top.sv
// Timer run control: start, stop, pause and timebase selection
`timescale 1ns/10ps
module trc_top #(
    parameter int NTRIG = 16,
    parameter int CW    = 16
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // Register port
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic [31:0]        rdata,
    // System modes and triggers
    input  wire logic          debug_mode,
    input  wire logic          wait_mode,
    input  wire logic [NTRIG-1:0] trig_in,
    input  wire logic [CW-1:0] global_count,
    input  wire logic          capture_in,
    // Timebase and status
    output logic [CW-1:0]      timebase,
    output logic               capture_ok,
    output logic               pwm_init,
    output logic               timer_overflow_flag,
    output logic               irq
);
    logic [31:0]             conf_r;
    trc_pkg::trc_conf_t      cf;
    logic                    enable_r;
    logic [CW-1:0]           count_r;
    logic [CW-1:0]           modulo_r;
    logic [trc_pkg::ST_W-1:0] status_r;
    logic [trc_pkg::ST_W-1:0] mask_r;
    trc_pkg::trc_state_t     state_r;
    trc_pkg::trc_state_t     state_nxt;
    logic                    rise;
    logic                    paused;
    logic                    trig_ok;
    logic                    wrap;
    logic                    count_wr;
    logic                    step;
    logic                    dbg_pause;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] want);
        hit = (a == want);
    endfunction

    assign cf.trigger_source_select =
        conf_r[trc_pkg::TRG_SRC_LO +: trc_pkg::TRG_SRC_W];
    assign cf.reload_on_trigger_edge = conf_r[trc_pkg::RELOAD_BIT];
    assign cf.stop_on_overflow       = conf_r[trc_pkg::STOP_OVF_BIT];
    assign cf.start_on_trigger_edge  = conf_r[trc_pkg::START_TRG_BIT];
    assign cf.global_timebase_select = conf_r[trc_pkg::GTB_BIT];
    assign cf.debug_behaviour        = conf_r[trc_pkg::DBG_LO +: 2];
    assign cf.wait_pause_select      = conf_r[trc_pkg::WAIT_BIT];

    trc_edge_detect #(
        .WIDTH (NTRIG)
    ) u_edge (
        .clk     (clk),
        .nrst    (nrst),
        .trig_in (trig_in),
        .sel     (cf.trigger_source_select),
        .rise    (rise)
    );

    // Reserved debug codes behave as continue
    assign dbg_pause = debug_mode &&
        (cf.debug_behaviour == trc_pkg::DBG_PAUSE);
    assign paused  = dbg_pause || (wait_mode && cf.wait_pause_select);
    assign trig_ok = rise && !paused;
    assign count_wr = wr && hit(addr, trc_pkg::ADDR_COUNT);
    assign step = (state_r == trc_pkg::ST_RUN) && !paused && !count_wr &&
                  !(trig_ok && cf.reload_on_trigger_edge);
    assign wrap = step && (count_r == modulo_r);

    // Run state machine
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            trc_pkg::ST_IDLE:
            begin
                if (enable_r)
                    state_nxt = cf.start_on_trigger_edge ?
                                trc_pkg::ST_WAIT : trc_pkg::ST_RUN;
            end
            trc_pkg::ST_WAIT:
            begin
                // Without start-on-trigger only re-enable restarts
                if (trig_ok && cf.start_on_trigger_edge)
                    state_nxt = trc_pkg::ST_RUN;
            end
            trc_pkg::ST_RUN:
            begin
                // Only a true wrap halts; reloads do not
                if (wrap && cf.stop_on_overflow)
                    state_nxt = trc_pkg::ST_WAIT;
            end
            default: state_nxt = trc_pkg::ST_IDLE;
        endcase
        if (!enable_r)
            state_nxt = trc_pkg::ST_IDLE;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_r <= trc_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Configuration and control registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            conf_r   <= trc_pkg::CONF_RESET;
            enable_r <= 1'b0;
            modulo_r <= trc_pkg::MODULO_RESET;
            mask_r   <= '0;
        end
        else if (wr)
        begin
            if (hit(addr, trc_pkg::ADDR_CONF))
                conf_r <= wdata & trc_pkg::CONF_WMASK;
            if (hit(addr, trc_pkg::ADDR_CTRL))
                enable_r <= wdata[0];
            if (hit(addr, trc_pkg::ADDR_MODULO))
                modulo_r <= wdata[CW-1:0];
            if (hit(addr, trc_pkg::ADDR_MASK))
                mask_r <= wdata[trc_pkg::ST_W-1:0];
        end
    end

    // Counter; runs to modulo even under global timebase
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            count_r <= trc_pkg::COUNT_RESET;
        else if (count_wr || (trig_ok && cf.reload_on_trigger_edge))
            count_r <= trc_pkg::COUNT_RESET;
        else if (step)
            count_r <= wrap ? trc_pkg::COUNT_RESET
                            : count_r + 1'b1;
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            status_r <= '0;
        else
        begin
            for (int i = 0; i < trc_pkg::ST_W; i++)
            begin
                if ((i == trc_pkg::ST_OVF && wrap) ||
                    (i == trc_pkg::ST_TRG && trig_ok))
                    status_r[i] <= 1'b1;
                else if (wr && hit(addr, trc_pkg::ADDR_STATUS) && wdata[i])
                    status_r[i] <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            timebase            <= '0;
            capture_ok          <= 1'b0;
            pwm_init            <= 1'b0;
            timer_overflow_flag <= 1'b0;
            irq                 <= 1'b0;
        end
        else
        begin
            timebase <= cf.global_timebase_select ? global_count
                                                  : count_r;
            capture_ok <= capture_in && !paused;
            pwm_init   <= trig_ok && cf.reload_on_trigger_edge;
            timer_overflow_flag <= status_r[trc_pkg::ST_OVF];
            irq <= |(status_r & mask_r);
        end
    end

    // Read port, data one cycle after strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= '0;
        else if (rd)
        begin
            unique case (1'b1)
                hit(addr, trc_pkg::ADDR_CONF):   rdata <= conf_r;
                hit(addr, trc_pkg::ADDR_CTRL):
                    rdata <= {29'h0, state_r};
                hit(addr, trc_pkg::ADDR_COUNT):
                    rdata <= {{(32-CW){1'b0}}, count_r};
                hit(addr, trc_pkg::ADDR_MODULO):
                    rdata <= {{(32-CW){1'b0}}, modulo_r};
                hit(addr, trc_pkg::ADDR_STATUS):
                    rdata <= {30'h0, status_r};
                hit(addr, trc_pkg::ADDR_MASK):
                    rdata <= {30'h0, mask_r};
                default: rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end
endmodule

// file: tb/trc_top_asserts.sv
// Port checker for the timer run-control block
`timescale 1ns/10ps
module trc_top_chk #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic          clk,
    input wire logic          nrst,
    // Register port
    input wire logic [7:0]    addr,
    input wire logic [31:0]   wdata,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [31:0]   rdata,
    // Modes, capture and timebase
    input wire logic          debug_mode,
    input wire logic          wait_mode,
    input wire logic          capture_in,
    input wire logic [CW-1:0] global_count,
    input wire logic [CW-1:0] timebase,
    input wire logic          capture_ok,
    input wire logic          pwm_init,
    input wire logic          timer_overflow_flag,
    input wire logic          irq
);
    logic [31:0] conf_r;
    logic [1:0]  mask_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Shadow of configuration and mask
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            conf_r <= 32'h0;
            mask_r <= 2'h0;
        end
        else if (wr && addr == trc_pkg::ADDR_CONF)
            conf_r <= wdata & trc_pkg::CONF_WMASK;
        else if (wr && addr == trc_pkg::ADDR_MASK)
            mask_r <= wdata[1:0];
    end
    rsvd_zero_a: assert property (
        $past(rd) && $past(addr) == trc_pkg::ADDR_CONF
        |-> (rdata & ~trc_pkg::CONF_WMASK) == 32'h0)
        else $error("reserved conf bits read nonzero");
    gtb_view_a: assert property (
        $past(conf_r[9]) |-> timebase == $past(global_count))
        else $error("timebase not following global count");
    wait_cap_a: assert property (
        (wait_mode && conf_r[5])[*3] |-> !capture_ok)
        else $error("capture passed in wait pause");
    dbg_cap_a: assert property (
        (debug_mode && conf_r[7:6] == trc_pkg::DBG_PAUSE)[*3] |-> !capture_ok)
        else $error("capture passed in debug pause");
    cap_pass_a: assert property (
        (!debug_mode && !wait_mode)[*3] ##0 capture_in |=> capture_ok)
        else $error("capture dropped while running");
    pulse_once_a: assert property (pwm_init |=> !pwm_init)
        else $error("reload pulse longer than one cycle");
    reload_only_a: assert property (pwm_init |-> conf_r[18])
        else $error("reload pulse with reload disabled");
    pause_trig_a: assert property (
        (wait_mode && conf_r[5])[*6] |-> !pwm_init)
        else $error("trigger acted while paused");
    ovf_irq_a: assert property (
        timer_overflow_flag && $past(mask_r[0]) |-> irq)
        else $error("unmasked overflow without irq");
    cover property (pwm_init);
    cover property ($rose(irq));
    cover property (capture_ok);
endmodule

bind trc_top trc_top_chk #(.CW(CW)) chk (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .debug_mode(debug_mode), .wait_mode(wait_mode),
    .capture_in(capture_in), .global_count(global_count),
    .timebase(timebase), .capture_ok(capture_ok), .pwm_init(pwm_init),
    .timer_overflow_flag(timer_overflow_flag), .irq(irq));

// file: tb/trc_trig_src.sv
// Trigger sources and external global timebase
`timescale 1ns/10ps
module trc_trig_src (
    // Clock
    input wire logic    clk,
    // Trigger levels and global count
    output logic [15:0] trig_in,
    output logic [15:0] global_count
);
    initial
    begin
        trig_in = 16'h0;
        global_count = 16'h0;
    end
    // Level high four cycles, then low four
    task automatic pulse(input int i);
        @(posedge clk);
        trig_in[i] <= 1'b1;
        repeat (4) @(posedge clk);
        trig_in[i] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// file: tb/trc_top_tb.sv
// Testbench for the timer run-control block
`timescale 1ns/10ps
module trc_top_tb;
    logic        clk;
    logic        nrst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        debug_mode;
    logic        wait_mode;
    logic        capture_in;
    logic [15:0] trig_in;
    logic [15:0] global_count;
    logic [15:0] timebase;
    logic        capture_ok;
    logic        pwm_init;
    logic        timer_overflow_flag;
    logic        irq;
    logic        pwm_seen;
    int          fails;
    int          n_checks;
    logic [31:0] tbl [6][4];
    trc_top uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .debug_mode(debug_mode),
        .wait_mode(wait_mode), .trig_in(trig_in),
        .global_count(global_count), .capture_in(capture_in),
        .timebase(timebase), .capture_ok(capture_ok),
        .pwm_init(pwm_init), .timer_overflow_flag(timer_overflow_flag),
        .irq(irq));
    trc_trig_src p (.clk(clk), .trig_in(trig_in),
        .global_count(global_count));
    always #5 clk = ~clk;
    always @(posedge clk) capture_in <= ~capture_in;
    always @(posedge clk) if (pwm_init === 1'b1) pwm_seen <= 1'b1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask
    task automatic wrap_up;
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (4000) @(posedge clk);
        fails++;
        wrap_up;
    end
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        debug_mode = 1'b0;
        wait_mode = 1'b0;
        capture_in = 1'b0;
        pwm_seen = 1'b0;
        tbl = '{'{32'h00, 1, 0, 0}, '{32'hc0, 1, 0, 1}, '{32'h40, 1, 0, 1},
            '{32'h80, 1, 0, 1}, '{32'h20, 0, 1, 0}, '{32'h00, 0, 1, 1}};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h1);
        rd_chk(8'h0c, 32'hffff);
        wr_reg(8'h00, 32'hffff_ffff);
        rd_chk(8'h00, 32'h0f07_02e0);
        rd_chk(8'h20, 32'h0);
        // Free run past modulo
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h0c, 32'h4);
        wr_reg(8'h14, 32'h1);
        wr_reg(8'h04, 32'h1);
        repeat (12) @(posedge clk);
        rd_chk(8'h04, 32'h4);
        chk(irq, 32'h1);
        rd_chk(8'h10, 32'h1);
        wr_reg(8'h14, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h10, 32'h3);
        wr_reg(8'h14, 32'h1);
        rd_chk(8'h10, 32'h0);
        chk(timer_overflow_flag, 32'h0);
        // Halt on overflow
        wr_reg(8'h00, 32'h0002_0000);
        wr_reg(8'h04, 32'h1);
        wr_reg(8'h08, 32'h0);
        rd_chk(8'h04, 32'h4);
        repeat (12) @(posedge clk);
        rd_chk(8'h04, 32'h2);
        rd_chk(8'h10, 32'h1);
        chk(irq, 32'h1);
        chk(timer_overflow_flag, 32'h1);
        rd_chk(8'h08, 32'h0);
        p.pulse(0);
        rd_chk(8'h04, 32'h2);
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h04, 32'h1);
        rd_chk(8'h04, 32'h4);
        // Start and restart on trigger 3
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h0c, 32'h20);
        wr_reg(8'h00, 32'h0307_0000);
        wr_reg(8'h04, 32'h1);
        p.pulse(5);
        rd_chk(8'h04, 32'h2);
        p.pulse(3);
        rd_chk(8'h04, 32'h4);
        chk(pwm_seen, 32'h1);
        repeat (40) @(posedge clk);
        rd_chk(8'h04, 32'h2);
        p.pulse(3);
        rd_chk(8'h04, 32'h4);
        // Trigger while paused in wait
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h00, 32'h0307_0020);
        wait_mode <= 1'b1;
        wr_reg(8'h04, 32'h1);
        p.pulse(3);
        rd_chk(8'h04, 32'h2);
        wait_mode <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(8'h04, 32'h2);
        // Debug and wait codes against overflow
        wr_reg(8'h0c, 32'h4);
        wr_reg(8'h08, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(8'h04, 32'h0);
            wr_reg(8'h00, tbl[i][0]);
            wr_reg(8'h10, 32'h3);
            debug_mode <= tbl[i][1][0];
            wait_mode <= tbl[i][2][0];
            wr_reg(8'h04, 32'h1);
            repeat (14) @(posedge clk);
            rd_chk(8'h10, tbl[i][3]);
            debug_mode <= 1'b0;
            wait_mode <= 1'b0;
        end
        // External global timebase
        wr_reg(8'h04, 32'h0);
        p.global_count <= 16'h1234;
        wr_reg(8'h00, 32'h0000_0200);
        wr_reg(8'h10, 32'h3);
        wr_reg(8'h04, 32'h1);
        repeat (14) @(posedge clk);
        chk(timebase, 32'h1234);
        rd_chk(8'h10, 32'h1);
        wrap_up;
    end
endmodule
